// File: rtl/dcm_defines.vh
// Purpose: Constants for the dual channel IO mode multiplexer
// Assumes: Included by bare name from every design file of the block
// Notes: Definitions only, guarded against double inclusion
// Operation
// - The base mode of each channel comes from the stored configuration, never from a command.
// - Bit-bang, serial engine and bus emulation modes are entered only by a bit-mode command.
// - Command code 0 returns to base mode, 1 selects async bit-bang, 2 selects the serial engine.
// - Command code 4 selects sync bit-bang, 8 selects bus emulation, 10 hex addresses opto serial.
// - With opto serial as base, code 10 hex holds its logic in reset and code 0 releases it.
// - Channel A may run any other mode while channel B runs opto serial; bus emulation on A takes B's pins as well.
// - When both channels run opto serial, all opto signals of both sit on channel B pins.
// - The serial engine exists on channel A only; a request on channel B is refused and leaves its mode unchanged.
// - Bus emulation takes both channels together as one multiplexed address/data bus.
// - In bit-bang over a FIFO, CPU FIFO or opto base, write and read strobes sit on ctrl bits 0 and 1.
// - In bit-bang over a serial UART base, write and read strobes sit on ctrl bits 2 and 3.
// - Channel B refuses bit-bang while its base mode is opto serial.
// - The wake input is off in serial engine, bus emulation and CPU FIFO modes, and in opto on A.
// - With no or a blank configuration memory both channels default to serial UART mode.
`ifndef DCM_DEFINES_VH
`define DCM_DEFINES_VH

// Stored base mode codes
`define DCM_BASE_UART 2'h0
`define DCM_BASE_FIFO 2'h1
`define DCM_BASE_CPU 2'h2
`define DCM_BASE_OPTO 2'h3

// Bit-mode command codes
`define DCM_CMD_RESET 8'h00
`define DCM_CMD_ABB 8'h01
`define DCM_CMD_SENG 8'h02
`define DCM_CMD_SBB 8'h04
`define DCM_CMD_MCU 8'h08
`define DCM_CMD_OPTO 8'h10

// Active mode state, one-hot
`define DCM_ST_W 5
`define DCM_ST_BASE 5'h01
`define DCM_ST_ABB 5'h02
`define DCM_ST_SBB 5'h04
`define DCM_ST_SENG 5'h08
`define DCM_ST_MCU 5'h10
`define DCM_ST_BASE_B 0
`define DCM_ST_ABB_B 1
`define DCM_ST_SBB_B 2
`define DCM_ST_SENG_B 3
`define DCM_ST_MCU_B 4

// Pin vector layout: data bits 0..7, ctrl bits 8..11
`define DCM_PINS 12
`define DCM_CTRL0 8
`define DCM_CTRL1 9
`define DCM_CTRL2 10
`define DCM_CTRL3 11

// Opto serial pin positions on a channel, second set for the far channel
`define DCM_OPTO_SDI 0
`define DCM_OPTO_CLK 1
`define DCM_OPTO_SDO 2
`define DCM_OPTO_CTS 3
`define DCM_OPTO2_SDI 4
`define DCM_OPTO2_CLK 5
`define DCM_OPTO2_SDO 6
`define DCM_OPTO2_CTS 7

`endif

// File: rtl/dcm_chan_mode.v
// Purpose: Per channel bit-mode command decoder and active mode state
// Assumes: Commands arrive on the local clock as one-cycle strobes
// Notes: Unknown codes and refused requests leave the state untouched
`timescale 1ns/100ps
`include "dcm_defines.vh"

module dcm_chan_mode #(
  parameter CMD_W = 8
)(
  input wire clk,
  input wire resetn,
  input wire cmd_valid,
  input wire [CMD_W-1:0] cmd_code,
  input wire [1:0] base_mode,
  input wire seng_allowed,
  input wire bb_allowed,
  output reg [`DCM_ST_W-1:0] state_ff,
  output reg opto_hold_ff,
  output reg refused_ff
);

  reg [`DCM_ST_W-1:0] nxt_state;
  reg nxt_opto_hold;
  reg nxt_refused;
  wire base_opto;

  assign base_opto = (base_mode == `DCM_BASE_OPTO);

  // Command decode; only a command moves the state away from base
  always @*
  begin
    nxt_state = state_ff;
    nxt_opto_hold = opto_hold_ff & base_opto;
    nxt_refused = 1'b0;
    if (cmd_valid)
    begin
      case (cmd_code)
        `DCM_CMD_RESET:
        begin
          nxt_state = `DCM_ST_BASE;
          nxt_opto_hold = 1'b0;
        end
        `DCM_CMD_ABB:
        begin
          if (bb_allowed)
            nxt_state = `DCM_ST_ABB;
          else
            nxt_refused = 1'b1;
        end
        `DCM_CMD_SENG:
        begin
          if (seng_allowed)
            nxt_state = `DCM_ST_SENG;
          else
            nxt_refused = 1'b1;
        end
        `DCM_CMD_SBB:
        begin
          if (bb_allowed)
            nxt_state = `DCM_ST_SBB;
          else
            nxt_refused = 1'b1;
        end
        `DCM_CMD_MCU:
          nxt_state = `DCM_ST_MCU;
        `DCM_CMD_OPTO:
        begin
          // Hold only makes sense when opto is the stored base
          if (base_opto)
          begin
            nxt_state = `DCM_ST_BASE;
            nxt_opto_hold = 1'b1;
          end
          else
            nxt_refused = 1'b1;
        end
        default:
          nxt_refused = 1'b1;
      endcase
    end
  end

  // State registers
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_ff <= `DCM_ST_BASE;
      opto_hold_ff <= 1'b0;
      refused_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      opto_hold_ff <= nxt_opto_hold;
      refused_ff <= nxt_refused;
    end
  end

endmodule

// File: rtl/dcm_io_mode_mux.v
// Purpose: Mode selection and pin multiplexing for two IO channels
// Assumes: Engines and command source run on clk; pins are asynchronous
// Notes: Pin enables are active low; all outputs come from flip-flops
`timescale 1ns/100ps
`include "dcm_defines.vh"

module dcm_io_mode_mux #(
  parameter CMD_W = 8
)(
  input wire clk,
  input wire resetn,
  input wire cfg_present,
  input wire [1:0] cfg_mode_a,
  input wire [1:0] cfg_mode_b,
  input wire cmd_valid_a,
  input wire [CMD_W-1:0] cmd_code_a,
  input wire cmd_valid_b,
  input wire [CMD_W-1:0] cmd_code_b,
  input wire [11:0] base_dout_a,
  input wire [11:0] base_den_a,
  input wire [11:0] base_dout_b,
  input wire [11:0] base_den_b,
  input wire [7:0] bb_dout_a,
  input wire [7:0] bb_den_a,
  input wire bb_wr_n_a,
  input wire bb_rd_n_a,
  input wire [7:0] bb_dout_b,
  input wire [7:0] bb_den_b,
  input wire bb_wr_n_b,
  input wire bb_rd_n_b,
  input wire [11:0] seng_dout,
  input wire [11:0] seng_den,
  input wire [23:0] mcu_dout,
  input wire [23:0] mcu_den,
  input wire opto_clk_a,
  input wire opto_sdo_a,
  input wire opto_clk_b,
  input wire opto_sdo_b,
  input wire [7:0] chan_a_data_bus_in,
  input wire [3:0] chan_a_ctrl_bus_in,
  input wire [7:0] chan_b_data_bus_in,
  input wire [3:0] chan_b_ctrl_bus_in,
  input wire wake_send_now_n_a,
  input wire wake_send_now_n_b,
  output reg [7:0] chan_a_data_bus_out,
  output reg [7:0] chan_a_data_bus_oe_n,
  output reg [3:0] chan_a_ctrl_bus_out,
  output reg [3:0] chan_a_ctrl_bus_oe_n,
  output reg [7:0] chan_b_data_bus_out,
  output reg [7:0] chan_b_data_bus_oe_n,
  output reg [3:0] chan_b_ctrl_bus_out,
  output reg [3:0] chan_b_ctrl_bus_oe_n,
  output reg [11:0] pins_a_ff,
  output reg [11:0] pins_b_ff,
  output reg opto_sdi_a_ff,
  output reg opto_cts_a_ff,
  output reg opto_sdi_b_ff,
  output reg opto_cts_b_ff,
  output reg [1:0] base_a_ff,
  output reg [1:0] base_b_ff,
  output wire [`DCM_ST_W-1:0] mode_a_ff,
  output wire [`DCM_ST_W-1:0] mode_b_ff,
  output reg mcu_active_ff,
  output reg opto_hold_a_ff,
  output reg opto_hold_b_ff,
  output wire cmd_refused_a_ff,
  output wire cmd_refused_b_ff,
  output reg wake_req_a_ff,
  output reg wake_req_b_ff
);

  reg [11:0] sync1_a_ff;
  reg [11:0] sync2_a_ff;
  reg [11:0] sync1_b_ff;
  reg [11:0] sync2_b_ff;
  reg [1:0] wake1_ff;
  reg [1:0] wake2_ff;
  reg [1:0] wake3_ff;
  reg [11:0] nxt_out_a;
  reg [11:0] nxt_oe_n_a;
  reg [11:0] nxt_out_b;
  reg [11:0] nxt_oe_n_b;
  reg [1:0] nxt_base_a;
  reg [1:0] nxt_base_b;
  wire hold_a;
  wire hold_b;
  wire both_opto;
  wire mcu_now;
  wire bb_a;
  wire bb_b;
  wire wake_en_a;
  wire wake_en_b;

  // Blank or missing configuration falls back to serial UART
  always @*
  begin
    if (cfg_present)
    begin
      nxt_base_a = cfg_mode_a;
      nxt_base_b = cfg_mode_b;
    end
    else
    begin
      nxt_base_a = `DCM_BASE_UART;
      nxt_base_b = `DCM_BASE_UART;
    end
  end

  // Command decoders; engine only offered on A, bit-bang gated on B
  dcm_chan_mode #(
    .CMD_W(CMD_W)
  ) u_mode_a (
    .clk(clk),
    .resetn(resetn),
    .cmd_valid(cmd_valid_a),
    .cmd_code(cmd_code_a),
    .base_mode(base_a_ff),
    .seng_allowed(1'b1),
    .bb_allowed(1'b1),
    .state_ff(mode_a_ff),
    .opto_hold_ff(hold_a),
    .refused_ff(cmd_refused_a_ff)
  );

  dcm_chan_mode #(
    .CMD_W(CMD_W)
  ) u_mode_b (
    .clk(clk),
    .resetn(resetn),
    .cmd_valid(cmd_valid_b),
    .cmd_code(cmd_code_b),
    .base_mode(base_b_ff),
    .seng_allowed(1'b0),
    .bb_allowed(base_b_ff != `DCM_BASE_OPTO),
    .state_ff(mode_b_ff),
    .opto_hold_ff(hold_b),
    .refused_ff(cmd_refused_b_ff)
  );

  // Either channel asking for bus emulation claims both
  assign mcu_now = mode_a_ff[`DCM_ST_MCU_B] | mode_b_ff[`DCM_ST_MCU_B];
  assign bb_a = mode_a_ff[`DCM_ST_ABB_B] | mode_a_ff[`DCM_ST_SBB_B];
  assign bb_b = mode_b_ff[`DCM_ST_ABB_B] | mode_b_ff[`DCM_ST_SBB_B];
  assign both_opto = (base_a_ff == `DCM_BASE_OPTO) && (base_b_ff == `DCM_BASE_OPTO) &&
    mode_a_ff[`DCM_ST_BASE_B] && mode_b_ff[`DCM_ST_BASE_B] && !mcu_now;

  // Wake input gating per active mode
  assign wake_en_a = !mcu_now && !mode_a_ff[`DCM_ST_SENG_B] &&
    !(mode_a_ff[`DCM_ST_BASE_B] && (base_a_ff == `DCM_BASE_CPU)) &&
    !(mode_a_ff[`DCM_ST_BASE_B] && (base_a_ff == `DCM_BASE_OPTO));
  assign wake_en_b = !mcu_now && !mode_b_ff[`DCM_ST_SENG_B] &&
    !(mode_b_ff[`DCM_ST_BASE_B] && (base_b_ff == `DCM_BASE_CPU));

  // Channel A pin functions; unassigned pins stay inputs
  always @*
  begin
    nxt_out_a = 12'h000;
    nxt_oe_n_a = 12'hFFF;
    if (mcu_now)
    begin
      nxt_out_a = mcu_dout[11:0];
      nxt_oe_n_a = ~mcu_den[11:0];
    end
    else if (mode_a_ff[`DCM_ST_SENG_B])
    begin
      nxt_out_a = seng_dout;
      nxt_oe_n_a = ~seng_den;
    end
    else if (bb_a)
    begin
      nxt_out_a[7:0] = bb_dout_a;
      nxt_oe_n_a[7:0] = ~bb_den_a;
      if (base_a_ff == `DCM_BASE_UART)
      begin
        nxt_out_a[`DCM_CTRL2] = bb_wr_n_a;
        nxt_out_a[`DCM_CTRL3] = bb_rd_n_a;
        nxt_oe_n_a[`DCM_CTRL2] = 1'b0;
        nxt_oe_n_a[`DCM_CTRL3] = 1'b0;
      end
      else
      begin
        nxt_out_a[`DCM_CTRL0] = bb_wr_n_a;
        nxt_out_a[`DCM_CTRL1] = bb_rd_n_a;
        nxt_oe_n_a[`DCM_CTRL0] = 1'b0;
        nxt_oe_n_a[`DCM_CTRL1] = 1'b0;
      end
    end
    else if (base_a_ff == `DCM_BASE_OPTO)
    begin
      // With both on opto, A's signals move over to B and A floats
      if (!both_opto)
      begin
        nxt_out_a[`DCM_OPTO_CLK] = opto_clk_a;
        nxt_out_a[`DCM_OPTO_SDO] = opto_sdo_a;
        nxt_oe_n_a[`DCM_OPTO_CLK] = 1'b0;
        nxt_oe_n_a[`DCM_OPTO_SDO] = 1'b0;
      end
    end
    else
    begin
      nxt_out_a = base_dout_a;
      nxt_oe_n_a = ~base_den_a;
    end
  end

  // Channel B pin functions, with A's opto set on the upper data bits
  always @*
  begin
    nxt_out_b = 12'h000;
    nxt_oe_n_b = 12'hFFF;
    if (mcu_now)
    begin
      nxt_out_b = mcu_dout[23:12];
      nxt_oe_n_b = ~mcu_den[23:12];
    end
    else if (bb_b)
    begin
      nxt_out_b[7:0] = bb_dout_b;
      nxt_oe_n_b[7:0] = ~bb_den_b;
      if (base_b_ff == `DCM_BASE_UART)
      begin
        nxt_out_b[`DCM_CTRL2] = bb_wr_n_b;
        nxt_out_b[`DCM_CTRL3] = bb_rd_n_b;
        nxt_oe_n_b[`DCM_CTRL2] = 1'b0;
        nxt_oe_n_b[`DCM_CTRL3] = 1'b0;
      end
      else
      begin
        nxt_out_b[`DCM_CTRL0] = bb_wr_n_b;
        nxt_out_b[`DCM_CTRL1] = bb_rd_n_b;
        nxt_oe_n_b[`DCM_CTRL0] = 1'b0;
        nxt_oe_n_b[`DCM_CTRL1] = 1'b0;
      end
    end
    else if (base_b_ff == `DCM_BASE_OPTO)
    begin
      // B opto never blocks channel A from its own mode
      nxt_out_b[`DCM_OPTO_CLK] = opto_clk_b;
      nxt_out_b[`DCM_OPTO_SDO] = opto_sdo_b;
      nxt_oe_n_b[`DCM_OPTO_CLK] = 1'b0;
      nxt_oe_n_b[`DCM_OPTO_SDO] = 1'b0;
      if (both_opto)
      begin
        nxt_out_b[`DCM_OPTO2_CLK] = opto_clk_a;
        nxt_out_b[`DCM_OPTO2_SDO] = opto_sdo_a;
        nxt_oe_n_b[`DCM_OPTO2_CLK] = 1'b0;
        nxt_oe_n_b[`DCM_OPTO2_SDO] = 1'b0;
      end
    end
    else
    begin
      nxt_out_b = base_dout_b;
      nxt_oe_n_b = ~base_den_b;
    end
  end

  // Pin input synchronisers; first stage feeds only the second
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1_a_ff <= 12'h000;
      sync2_a_ff <= 12'h000;
      sync1_b_ff <= 12'h000;
      sync2_b_ff <= 12'h000;
      wake1_ff <= 2'h3;
      wake2_ff <= 2'h3;
      wake3_ff <= 2'h3;
    end
    else
    begin
      sync1_a_ff <= {chan_a_ctrl_bus_in, chan_a_data_bus_in};
      sync2_a_ff <= sync1_a_ff;
      sync1_b_ff <= {chan_b_ctrl_bus_in, chan_b_data_bus_in};
      sync2_b_ff <= sync1_b_ff;
      wake1_ff <= {wake_send_now_n_b, wake_send_now_n_a};
      wake2_ff <= wake1_ff;
      wake3_ff <= wake2_ff;
    end
  end

  // Output registers, pins and status
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      chan_a_data_bus_out <= 8'h00;
      chan_a_data_bus_oe_n <= 8'hFF;
      chan_a_ctrl_bus_out <= 4'h0;
      chan_a_ctrl_bus_oe_n <= 4'hF;
      chan_b_data_bus_out <= 8'h00;
      chan_b_data_bus_oe_n <= 8'hFF;
      chan_b_ctrl_bus_out <= 4'h0;
      chan_b_ctrl_bus_oe_n <= 4'hF;
      pins_a_ff <= 12'h000;
      pins_b_ff <= 12'h000;
      opto_sdi_a_ff <= 1'b0;
      opto_cts_a_ff <= 1'b0;
      opto_sdi_b_ff <= 1'b0;
      opto_cts_b_ff <= 1'b0;
      base_a_ff <= `DCM_BASE_UART;
      base_b_ff <= `DCM_BASE_UART;
      mcu_active_ff <= 1'b0;
      opto_hold_a_ff <= 1'b0;
      opto_hold_b_ff <= 1'b0;
      wake_req_a_ff <= 1'b0;
      wake_req_b_ff <= 1'b0;
    end
    else
    begin
      chan_a_data_bus_out <= nxt_out_a[7:0];
      chan_a_data_bus_oe_n <= nxt_oe_n_a[7:0];
      chan_a_ctrl_bus_out <= nxt_out_a[11:8];
      chan_a_ctrl_bus_oe_n <= nxt_oe_n_a[11:8];
      chan_b_data_bus_out <= nxt_out_b[7:0];
      chan_b_data_bus_oe_n <= nxt_oe_n_b[7:0];
      chan_b_ctrl_bus_out <= nxt_out_b[11:8];
      chan_b_ctrl_bus_oe_n <= nxt_oe_n_b[11:8];
      pins_a_ff <= sync2_a_ff;
      pins_b_ff <= sync2_b_ff;
      // A's opto inputs come from B pins when both run opto
      if (both_opto)
      begin
        opto_sdi_a_ff <= sync2_b_ff[`DCM_OPTO2_SDI];
        opto_cts_a_ff <= sync2_b_ff[`DCM_OPTO2_CTS];
      end
      else
      begin
        opto_sdi_a_ff <= sync2_a_ff[`DCM_OPTO_SDI];
        opto_cts_a_ff <= sync2_a_ff[`DCM_OPTO_CTS];
      end
      opto_sdi_b_ff <= sync2_b_ff[`DCM_OPTO_SDI];
      opto_cts_b_ff <= sync2_b_ff[`DCM_OPTO_CTS];
      base_a_ff <= nxt_base_a;
      base_b_ff <= nxt_base_b;
      mcu_active_ff <= mcu_now;
      opto_hold_a_ff <= hold_a;
      opto_hold_b_ff <= hold_b;
      // Falling edge of the synced wake pin, only where allowed
      wake_req_a_ff <= wake_en_a & wake3_ff[0] & ~wake2_ff[0];
      wake_req_b_ff <= wake_en_b & wake3_ff[1] & ~wake2_ff[1];
    end
  end

endmodule

// File: verif/dcm_io_mode_mux_assertions.sv
// Purpose: Port-level checks on the dual channel mode multiplexer
// Assumes: Bound to dcm_io_mode_mux; one clock domain
// Notes: Pin checks look one edge after the mode and base flops
`timescale 1ns/100ps
`include "dcm_defines.vh"
module dcm_mux_chk #(
  parameter CMD_W = 8
)(
  input wire logic clk,
  input wire logic resetn,
  input wire logic cfg_present,
  input wire logic cmd_valid_a,
  input wire logic [CMD_W-1:0] cmd_code_a,
  input wire logic cmd_valid_b,
  input wire logic [CMD_W-1:0] cmd_code_b,
  input wire logic bb_wr_n_a,
  input wire logic bb_rd_n_a,
  input wire logic opto_clk_a,
  input wire logic [3:0] chan_a_ctrl_bus_out,
  input wire logic [7:0] chan_a_data_bus_oe_n,
  input wire logic [7:0] chan_b_data_bus_out,
  input wire logic [1:0] base_a_ff,
  input wire logic [1:0] base_b_ff,
  input wire logic [`DCM_ST_W-1:0] mode_a_ff,
  input wire logic [`DCM_ST_W-1:0] mode_b_ff,
  input wire logic mcu_active_ff,
  input wire logic opto_hold_a_ff,
  input wire logic cmd_refused_b_ff,
  input wire logic wake_req_a_ff
);
  // All checks share the one clock and its reset
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  abb_enter_a: assert property (
    cmd_valid_a && cmd_code_a == `DCM_CMD_ABB && mode_a_ff == `DCM_ST_BASE && !mcu_active_ff
    |=> mode_a_ff == `DCM_ST_ABB) else $error("Async bit-bang not entered");
  mcu_both_a: assert property (
    cmd_valid_a && cmd_code_a == `DCM_CMD_MCU |=> mode_a_ff == `DCM_ST_MCU ##1 mcu_active_ff)
    else $error("Bus emulation did not take both channels");
  engine_b_off_a: assert property (
    cmd_valid_b && cmd_code_b == `DCM_CMD_SENG
    |=> cmd_refused_b_ff && mode_b_ff != `DCM_ST_SENG) else $error("Engine ran on B");
  opto_hold_a: assert property (
    cmd_valid_a && cmd_code_a == `DCM_CMD_OPTO && base_a_ff == `DCM_BASE_OPTO
    |=> ##1 opto_hold_a_ff) else $error("Opto logic not held");
  bb_refuse_b_a: assert property (
    cmd_valid_b && cmd_code_b == `DCM_CMD_ABB && base_b_ff == `DCM_BASE_OPTO
    |=> cmd_refused_b_ff && $stable(mode_b_ff)) else $error("Bit-bang taken on opto B");
  uart_strobe_a: assert property (
    mode_a_ff == `DCM_ST_ABB && base_a_ff == `DCM_BASE_UART && mode_b_ff != `DCM_ST_MCU
    |=> chan_a_ctrl_bus_out[3:2] == {$past(bb_rd_n_a), $past(bb_wr_n_a)})
    else $error("Strobes off ctrl bits 2 and 3");
  // Both channels opto: A released, far clock lands on B pin 5
  opto_route_a: assert property (
    base_a_ff == `DCM_BASE_OPTO && base_b_ff == `DCM_BASE_OPTO && mode_a_ff == `DCM_ST_BASE
    && mode_b_ff == `DCM_ST_BASE && !mcu_active_ff
    |=> chan_a_data_bus_oe_n == 8'hFF && chan_b_data_bus_out[5] == $past(opto_clk_a))
    else $error("Opto signals not on B");
  wake_off_a: assert property (
    (base_a_ff == `DCM_BASE_CPU && mode_a_ff == `DCM_ST_BASE) [*4] |-> !wake_req_a_ff)
    else $error("Wake seen in CPU FIFO mode");
  blank_cfg_a: assert property (
    !cfg_present |=> base_a_ff == `DCM_BASE_UART && base_b_ff == `DCM_BASE_UART)
    else $error("Blank config not UART");

  cover property (mcu_active_ff);
  cover property (opto_hold_a_ff);
  cover property (wake_req_a_ff);
endmodule

// File: verif/dcm_pin_model.sv
// Purpose: External logic on the pins of both channels
// Assumes: Enables are low while the mux drives a pin
// Notes: Released pins show ext values or a pattern that flips each cycle
`timescale 1ns/100ps
module dcm_pin_model (
  input wire logic clk,
  input wire logic ext_en,
  input wire logic [11:0] ext_a,
  input wire logic [11:0] ext_b,
  input wire logic [11:0] out_a,
  input wire logic [11:0] oe_n_a,
  input wire logic [11:0] out_b,
  input wire logic [11:0] oe_n_b,
  output wire logic [11:0] pin_a,
  output wire logic [11:0] pin_b
);
  logic [11:0] pat_ff = 12'h5A5;
  // Flip the idle pattern so a stale level never passes for data
  always @(posedge clk)
    pat_ff <= ~pat_ff;
  // Wire level from both parties; the mux wins where it drives
  assign pin_a = (~oe_n_a & out_a) | (oe_n_a & (ext_en ? ext_a : pat_ff));
  assign pin_b = (~oe_n_b & out_b) | (oe_n_b & (ext_en ? ext_b : pat_ff));
endmodule

// File: verif/testbench.sv
// Purpose: Self-checking bench for the dual channel mode multiplexer
// Assumes: Commands are one-cycle strobes, config is held steady
// Notes: Engine inputs hold fixed patterns so routing is visible
`timescale 1ns/100ps
`include "dcm_defines.vh"
module testbench;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic cfg_present, cmd_valid_a, cmd_valid_b, bb_wr_n_a, bb_rd_n_a, wake_a, ext_en;
  logic opto_clk_a, opto_sdo_a, opto_clk_b, opto_sdo_b, bb_wr_n_b, bb_rd_n_b;
  logic [11:0] seng_dout, seng_den;
  logic [23:0] mcu_dout, mcu_den;
  logic [1:0] cfg_mode_a, cfg_mode_b;
  logic [7:0] cmd_code_a, cmd_code_b, bb_dout_a, bb_den_a;
  logic [11:0] base_dout_a, base_den_a, ext_a, ext_b;
  wire [11:0] pin_a, pin_b, pins_a_ff;
  wire [7:0] chan_a_data_bus_out, chan_a_data_bus_oe_n, chan_b_data_bus_out, chan_b_data_bus_oe_n;
  wire [3:0] chan_a_ctrl_bus_out, chan_a_ctrl_bus_oe_n, chan_b_ctrl_bus_out, chan_b_ctrl_bus_oe_n;
  wire [4:0] mode_a_ff, mode_b_ff;
  wire [1:0] base_a_ff, base_b_ff;
  wire mcu_active_ff, opto_hold_a_ff, cmd_refused_a_ff, cmd_refused_b_ff, wake_req_a_ff;
  wire opto_sdi_a_ff;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;

  always #2.5 clk = ~clk;

  dcm_io_mode_mux dcm_io_mode_mux_inst (
    .clk, .resetn, .cfg_present, .cfg_mode_a, .cfg_mode_b, .cmd_valid_a, .cmd_code_a,
    .cmd_valid_b, .cmd_code_b, .base_dout_a, .base_den_a, .base_dout_b(12'hA5A),
    .base_den_b(12'h0F0), .bb_dout_a, .bb_den_a, .bb_wr_n_a, .bb_rd_n_a,
    .bb_dout_b(8'h3C), .bb_den_b(8'hF0), .bb_wr_n_b, .bb_rd_n_b,
    .seng_dout, .seng_den, .mcu_dout, .mcu_den,
    .opto_clk_a, .opto_sdo_a, .opto_clk_b, .opto_sdo_b,
    .chan_a_data_bus_in(pin_a[7:0]), .chan_a_ctrl_bus_in(pin_a[11:8]),
    .chan_b_data_bus_in(pin_b[7:0]), .chan_b_ctrl_bus_in(pin_b[11:8]),
    .wake_send_now_n_a(wake_a), .wake_send_now_n_b(1'b1),
    .chan_a_data_bus_out, .chan_a_data_bus_oe_n, .chan_a_ctrl_bus_out, .chan_a_ctrl_bus_oe_n,
    .chan_b_data_bus_out, .chan_b_data_bus_oe_n, .chan_b_ctrl_bus_out, .chan_b_ctrl_bus_oe_n,
    .pins_a_ff, .pins_b_ff(), .opto_sdi_a_ff, .opto_cts_a_ff(), .opto_sdi_b_ff(),
    .opto_cts_b_ff(), .base_a_ff, .base_b_ff, .mode_a_ff, .mode_b_ff, .mcu_active_ff,
    .opto_hold_a_ff, .opto_hold_b_ff(), .cmd_refused_a_ff, .cmd_refused_b_ff,
    .wake_req_a_ff, .wake_req_b_ff());

  dcm_pin_model dcm_pin_model_inst (
    .clk(clk), .ext_en(ext_en), .ext_a(ext_a), .ext_b(ext_b),
    .out_a({chan_a_ctrl_bus_out, chan_a_data_bus_out}),
    .oe_n_a({chan_a_ctrl_bus_oe_n, chan_a_data_bus_oe_n}),
    .out_b({chan_b_ctrl_bus_out, chan_b_data_bus_out}),
    .oe_n_b({chan_b_ctrl_bus_oe_n, chan_b_data_bus_oe_n}), .pin_a(pin_a), .pin_b(pin_b));

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One-cycle strobe; state answers on the edge that takes it
  task automatic cmd(input bit ch_b, input logic [7:0] code);
    @(posedge clk);
    cmd_valid_a <= !ch_b;
    cmd_valid_b <= ch_b;
    cmd_code_a <= code;
    cmd_code_b <= code;
    @(posedge clk);
    cmd_valid_a <= 1'b0;
    cmd_valid_b <= 1'b0;
    #1;
  endtask

  // Base flops and pins need two edges to follow a config change
  task automatic set_cfg(input logic [1:0] ma, input logic [1:0] mb);
    @(posedge clk);
    cfg_mode_a <= ma;
    cfg_mode_b <= mb;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic t_codes();
    logic [7:0] codes [3] = '{`DCM_CMD_ABB, `DCM_CMD_SBB, `DCM_CMD_SENG};
    logic [4:0] sts [3] = '{`DCM_ST_ABB, `DCM_ST_SBB, `DCM_ST_SENG};
    set_cfg(`DCM_BASE_UART, `DCM_BASE_UART);
    for (int i = 0; i < 3; i++)
    begin
      cmd(0, codes[i]);
      chk("mode a", sts[i], mode_a_ff);
      cmd(0, `DCM_CMD_RESET);
      chk("mode a base", `DCM_ST_BASE, mode_a_ff);
    end
    cmd(0, `DCM_CMD_SENG);
    @(posedge clk);
    #1;
    chk("engine pins", {seng_dout, 12'(~seng_den)},
      {chan_a_ctrl_bus_out, chan_a_data_bus_out, chan_a_ctrl_bus_oe_n, chan_a_data_bus_oe_n});
    cmd(0, `DCM_CMD_MCU);
    chk("mcu mode", `DCM_ST_MCU, mode_a_ff);
    @(posedge clk);
    #1;
    chk("mcu owner", 1'b1, mcu_active_ff);
    chk("mcu b pins", {mcu_dout[23:12], 12'(~mcu_den[23:12])},
      {chan_b_ctrl_bus_out, chan_b_data_bus_out, chan_b_ctrl_bus_oe_n, chan_b_data_bus_oe_n});
    cmd(0, `DCM_CMD_RESET);
    cmd(1, `DCM_CMD_RESET);
    @(posedge clk);
    #1;
    chk("mcu left", 1'b0, mcu_active_ff);
    $display("mode codes done");
  endtask

  task automatic t_strobe();
    int lo;
    for (int i = 0; i < 2; i++)
    begin
      lo = i ? 0 : 2;
      set_cfg(i ? `DCM_BASE_FIFO : `DCM_BASE_UART, `DCM_BASE_UART);
      chk("base oe", 12'(~base_den_a), {chan_a_ctrl_bus_oe_n, chan_a_data_bus_oe_n});
      cmd(0, `DCM_CMD_ABB);
      @(posedge clk);
      #1;
      chk("strobes", {bb_rd_n_a, bb_wr_n_a}, chan_a_ctrl_bus_out[lo+:2]);
      chk("strobe oe", 2'h0, chan_a_ctrl_bus_oe_n[lo+:2]);
      chk("bb oe", 8'(~bb_den_a), chan_a_data_bus_oe_n);
      cmd(0, `DCM_CMD_RESET);
    end
    $display("strobe placement done");
  endtask

  task automatic t_refuse();
    set_cfg(`DCM_BASE_UART, `DCM_BASE_UART);
    cmd(1, `DCM_CMD_SENG);
    chk("engine on b", {1'b1, `DCM_ST_BASE}, {cmd_refused_b_ff, mode_b_ff});
    cmd(1, `DCM_CMD_ABB);
    @(posedge clk);
    #1;
    chk("b strobes", {bb_rd_n_b, bb_wr_n_b}, chan_b_ctrl_bus_out[3:2]);
    cmd(1, `DCM_CMD_RESET);
    cmd(0, `DCM_CMD_OPTO);
    chk("opto code uart", 1'b1, cmd_refused_a_ff);
    set_cfg(`DCM_BASE_UART, `DCM_BASE_OPTO);
    cmd(1, `DCM_CMD_ABB);
    chk("abb on opto b", {1'b1, `DCM_ST_BASE}, {cmd_refused_b_ff, mode_b_ff});
    cmd(1, `DCM_CMD_SBB);
    chk("sbb on opto b", {1'b1, `DCM_ST_BASE}, {cmd_refused_b_ff, mode_b_ff});
    cmd(0, `DCM_CMD_ABB);
    chk("a beside opto b", `DCM_ST_ABB, mode_a_ff);
    cmd(0, `DCM_CMD_RESET);
    $display("refusals done");
  endtask

  task automatic t_opto();
    set_cfg(`DCM_BASE_OPTO, `DCM_BASE_OPTO);
    chk("a released", 8'hFF, chan_a_data_bus_oe_n);
    chk("opto on b", {opto_sdo_a, opto_clk_a, opto_sdo_b, opto_clk_b},
      {chan_b_data_bus_out[6:5], chan_b_data_bus_out[2:1]});
    chk("opto b oe", 4'h0, {chan_b_data_bus_oe_n[6:5], chan_b_data_bus_oe_n[2:1]});
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk);
      ext_b[4] <= i[0];
      repeat (5) @(posedge clk);
      #1;
      chk("a sdi from b", i[0], opto_sdi_a_ff);
    end
    cmd(0, `DCM_CMD_OPTO);
    @(posedge clk);
    #1;
    chk("opto held", 1'b1, opto_hold_a_ff);
    cmd(0, `DCM_CMD_RESET);
    @(posedge clk);
    #1;
    chk("opto freed", 1'b0, opto_hold_a_ff);
    $display("opto routing done");
  endtask

  task automatic t_wake(input logic [1:0] base, input logic exp);
    logic seen;
    seen = 1'b0;
    set_cfg(base, `DCM_BASE_UART);
    chk("pins a", ext_a & ~base_den_a, pins_a_ff & ~base_den_a);
    @(posedge clk);
    wake_a <= 1'b0;
    repeat (8)
    begin
      @(posedge clk);
      #1;
      seen = seen | wake_req_a_ff;
    end
    @(posedge clk);
    wake_a <= 1'b1;
    chk("wake pulse", exp, seen);
    repeat (6) @(posedge clk);
    $display("wake test done");
  endtask

  // Cut a hang short; the run needs well under 1000 cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      errors++;
      end_sim();
    end
  end

  // Main sequence
  initial
  begin
    cfg_present = 1'b0;
    cfg_mode_a = `DCM_BASE_FIFO;
    cfg_mode_b = `DCM_BASE_CPU;
    cmd_valid_a = 1'b0;
    cmd_valid_b = 1'b0;
    cmd_code_a = 8'h00;
    cmd_code_b = 8'h00;
    bb_wr_n_a = 1'b0;
    bb_wr_n_b = 1'b1;
    bb_rd_n_b = 1'b0;
    seng_dout = 12'h9C3;
    seng_den = 12'h00F;
    mcu_dout = 24'h5A3C96;
    mcu_den = 24'h00FF0F;
    bb_rd_n_a = 1'b1;
    bb_dout_a = 8'hC6;
    bb_den_a = 8'h5F;
    base_dout_a = 12'h3A5;
    base_den_a = 12'h0F3;
    {opto_clk_a, opto_sdo_a, opto_clk_b, opto_sdo_b} = 4'h6;
    wake_a = 1'b1;
    ext_en = 1'b1;
    ext_a = 12'hA5C;
    ext_b = 12'h36C;
    repeat (10) @(posedge clk);
    chk("oe in reset", 24'hFFF, {chan_a_ctrl_bus_oe_n, chan_a_data_bus_oe_n});
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("blank cfg", 4'h0, {base_a_ff, base_b_ff});
    @(posedge clk);
    cfg_present <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("stored cfg", {`DCM_BASE_FIFO, `DCM_BASE_CPU}, {base_a_ff, base_b_ff});
    t_codes();
    t_strobe();
    t_refuse();
    t_opto();
    t_wake(`DCM_BASE_UART, 1'b1);
    t_wake(`DCM_BASE_CPU, 1'b0);
    end_sim();
  end
endmodule

bind dcm_io_mode_mux dcm_mux_chk #(.CMD_W(CMD_W)) dcm_mux_chk_inst (
  .clk, .resetn, .cfg_present, .cmd_valid_a, .cmd_code_a, .cmd_valid_b, .cmd_code_b,
  .bb_wr_n_a, .bb_rd_n_a, .opto_clk_a, .chan_a_ctrl_bus_out, .chan_a_data_bus_oe_n,
  .chan_b_data_bus_out, .base_a_ff, .base_b_ff, .mode_a_ff, .mode_b_ff, .mcu_active_ff,
  .opto_hold_a_ff, .cmd_refused_b_ff, .wake_req_a_ff);
